// *** logic/dprfe_consts.vh ***
// Constants for the dual-port memory with FIFO controller and check-bit logic
`ifndef DPRFE_CONSTS_VH
`define DPRFE_CONSTS_VH
`define DPRFE_AW 15
`define DPRFE_WW 72
`define DPRFE_DW 64
`define DPRFE_OW 74
`define DPRFE_WORDS 512
`define DPRFE_WIX 9
`define DPRFE_PW 16
`define DPRFE_WW7 7'h48
`define DPRFE_LANE_BITS 3'h6
`define DPRFE_C18 3'h4
`define DPRFE_C36 3'h5
`define DPRFE_C72 3'h6
`define DPRFE_W0 7'h01
`define DPRFE_W1 7'h02
`define DPRFE_W2 7'h04
`define DPRFE_W3 7'h09
`define DPRFE_W4 7'h12
`define DPRFE_W5 7'h24
`define DPRFE_W6 7'h48
`define DPRFE_WM_READ_FIRST 2'h0
`define DPRFE_WM_WRITE_FIRST 2'h1
`define DPRFE_WM_NO_CHANGE 2'h2
`define DPRFE_CAP_FULL 17'h08000
`define DPRFE_CAP_HALF 17'h04000
`define DPRFE_ECC_POS_END 8'h48
`endif

// *** logic/dprfe_ram.v ***
// Dual-port memory with aspect ratios, split mode, check bits, FIFO and cascade
`timescale 1ns/1ps
`default_nettype none
`include "dprfe_consts.vh"

module dprfe_port (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire en,
	input wire we,
	input wire [`DPRFE_AW-1:0] addr,
	input wire [`DPRFE_WW-1:0] din,
	input wire addr_latch,
	input wire pipe_en,
	input wire [1:0] wmode,
	input wire cap_rd,
	input wire cap_wr,
	input wire [`DPRFE_OW-1:0] rd_val,
	input wire [`DPRFE_OW-1:0] wr_val,
	output reg go,
	output reg we_q,
	output reg [`DPRFE_AW-1:0] addr_q,
	output reg [`DPRFE_WW-1:0] din_q,
	output reg [`DPRFE_OW-1:0] dout
);
	reg tick_reg;
	reg [`DPRFE_OW-1:0] raw_reg;
	reg load;
	reg [`DPRFE_OW-1:0] capv;

	// The enable stands in for the port clock: one op per enabled edge
	always @(posedge clk) begin
		if (rst) begin
			tick_reg <= 1'b0;
			go <= 1'b0;
			we_q <= 1'b0;
			addr_q <= {`DPRFE_AW{1'b0}};
			din_q <= {`DPRFE_WW{1'b0}};
		end else begin
			tick_reg <= ce;
			go <= ce & en;
			if (ce) begin
				we_q <= we;
				din_q <= din;
				if (en | ~addr_latch)
					addr_q <= addr;
			end
		end
	end

	always @* begin
		load = 1'b0;
		capv = raw_reg;
		if (cap_rd) begin
			load = 1'b1;
			capv = rd_val;
		end else if (cap_wr) begin
			case (wmode)
			`DPRFE_WM_READ_FIRST: begin
				load = 1'b1;
				capv = rd_val;
			end
			`DPRFE_WM_WRITE_FIRST: begin
				load = 1'b1;
				capv = wr_val;
			end
			default: load = 1'b0;
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			raw_reg <= {`DPRFE_OW{1'b0}};
			dout <= {`DPRFE_OW{1'b0}};
		end else begin
			if (load)
				raw_reg <= capv;
			if (pipe_en) begin
				if (tick_reg)
					dout <= raw_reg;
			end else if (load) begin
				dout <= capv;
			end
		end
	end
endmodule

module dprfe_ram (
	input wire ref_clk,
	input wire rst,
	input wire ce_a,
	input wire en_a,
	input wire we_a,
	input wire [`DPRFE_AW-1:0] addr_a,
	input wire [`DPRFE_WW-1:0] din_a,
	input wire [2:0] wcode_a,
	input wire half_sel_a,
	input wire pipe_a,
	input wire [1:0] wmode_a,
	input wire ce_b,
	input wire en_b,
	input wire we_b,
	input wire [`DPRFE_AW-1:0] addr_b,
	input wire [`DPRFE_WW-1:0] din_b,
	input wire [2:0] wcode_b,
	input wire half_sel_b,
	input wire pipe_b,
	input wire [1:0] wmode_b,
	input wire addr_latch,
	input wire half_mode,
	input wire split_read_write_mode,
	input wire ecc_en,
	input wire pwr_gate,
	input wire fifo_mode,
	input wire fifo_dual,
	input wire fifo_half,
	input wire [`DPRFE_PW-1:0] af_thresh,
	input wire [`DPRFE_PW-1:0] ae_thresh,
	input wire casc_sel_b,
	input wire [`DPRFE_WW-1:0] casc_in,
	input wire [`DPRFE_DW-1:0] enc_in,
	input wire [`DPRFE_WW-1:0] dec_in,
	output wire [`DPRFE_WW-1:0] dout_a,
	output wire [`DPRFE_WW-1:0] dout_b,
	output wire sbit_err,
	output wire dbit_err,
	output wire [`DPRFE_WW-1:0] casc_out,
	output reg fifo_full,
	output reg fifo_empty,
	output reg fifo_almost_full,
	output reg fifo_almost_empty,
	output reg [`DPRFE_WW-1:0] enc_out,
	output reg [`DPRFE_DW-1:0] dec_out,
	output reg dec_sbit,
	output reg dec_dbit
);
	reg [`DPRFE_WW-1:0] mem [0:`DPRFE_WORDS-1];
	wire go_a, go_b, we_qa, we_qb;
	wire [`DPRFE_AW-1:0] aq_a, aq_b;
	wire [`DPRFE_WW-1:0] dq_a, dq_b;
	wire [`DPRFE_OW-1:0] out_a, out_b;
	reg sleep_reg;
	reg [2:0] ca, cb;
	reg [`DPRFE_PW-1:0] wcnt_reg, rcnt_reg, wgray_reg, rgray_reg;
	reg [`DPRFE_PW-1:0] wg_s1, wg_s2, rg_s1, rg_s2;
	reg [`DPRFE_PW-1:0] r_seen, w_seen, wslot, rslot, fill_w, fill_r;
	reg [`DPRFE_PW-1:0] wcnt_next, rcnt_next;
	reg [16:0] cap, step_w, step_r;
	reg full_now, empty_now, wr_fire, rd_fire;
	reg wa_fire, wb_fire, cap_rd_a, cap_rd_b, cap_wr_a, cap_wr_b;
	reg [`DPRFE_AW-1:0] ea, eb;
	reg [`DPRFE_WIX-1:0] word_a, word_b;
	reg [6:0] off_a, off_b;
	reg [`DPRFE_WW-1:0] mask_a, mask_b, wdat_a, rword_b;
	reg [`DPRFE_OW-1:0] rd_a, rd_b, wv_a, wv_b, dec_b;
	wire [`DPRFE_OW-1:0] dec_b_ext;

	function [6:0] wid;
		input [2:0] c;
		begin
			case (c)
			3'h0: wid = `DPRFE_W0;
			3'h1: wid = `DPRFE_W1;
			3'h2: wid = `DPRFE_W2;
			3'h3: wid = `DPRFE_W3;
			3'h4: wid = `DPRFE_W4;
			3'h5: wid = `DPRFE_W5;
			default: wid = `DPRFE_W6;
			endcase
		end
	endfunction

	function [`DPRFE_WW-1:0] lmask;
		input [2:0] c;
		begin
			lmask = {`DPRFE_WW{1'b1}} >> (`DPRFE_WW7 - wid(c));
		end
	endfunction

	// Narrow codes index a 64-bit word, wide codes the full 72 bits
	function [`DPRFE_WIX-1:0] word_of;
		input [`DPRFE_AW-1:0] a;
		input [2:0] c;
		input h;
		input hs;
		reg [`DPRFE_AW-1:0] t;
		begin
			t = a >> (`DPRFE_LANE_BITS - c);
			word_of = h ? {hs, t[`DPRFE_WIX-2:0]} : t[`DPRFE_WIX-1:0];
		end
	endfunction

	function [6:0] off_of;
		input [`DPRFE_AW-1:0] a;
		input [2:0] c;
		reg [`DPRFE_AW-1:0] lane;
		reg [13:0] prod;
		begin
			lane = a & ~({`DPRFE_AW{1'b1}} << (`DPRFE_LANE_BITS - c));
			prod = lane[6:0] * wid(c);
			off_of = prod[6:0];
		end
	endfunction

	// Data bits sit at non-power-of-two codeword positions
	function [7:0] ecc_chk;
		input [`DPRFE_DW-1:0] d;
		reg [7:0] p;
		reg [7:0] c;
		integer j;
		begin
			c = 8'h00;
			j = 0;
			for (p = 8'h01; p < `DPRFE_ECC_POS_END; p = p + 8'h01) begin
				if ((p & (p - 8'h01)) != 8'h00) begin
					if (d[j])
						c[6:0] = c[6:0] ^ p[6:0];
					j = j + 1;
				end
			end
			c[7] = (^d) ^ (^c[6:0]);
			ecc_chk = c;
		end
	endfunction

	function [`DPRFE_OW-1:0] ecc_dec;
		input [`DPRFE_WW-1:0] cw;
		reg [7:0] p;
		reg [7:0] c;
		reg [6:0] syn;
		reg [`DPRFE_DW-1:0] d;
		reg par;
		integer j;
		begin
			d = cw[`DPRFE_DW-1:0];
			c = ecc_chk(d);
			syn = c[6:0] ^ cw[70:64];
			par = ^cw;
			j = 0;
			for (p = 8'h01; p < `DPRFE_ECC_POS_END; p = p + 8'h01) begin
				if ((p & (p - 8'h01)) != 8'h00) begin
					if (par && p[6:0] == syn)
						d[j] = ~d[j];
					j = j + 1;
				end
			end
			ecc_dec = {~par & (syn != 7'h00), par, cw[71:64], d};
		end
	endfunction

	function [`DPRFE_PW-1:0] g2b;
		input [`DPRFE_PW-1:0] g;
		integer i;
		begin
			g2b[`DPRFE_PW-1] = g[`DPRFE_PW-1];
			for (i = `DPRFE_PW - 2; i >= 0; i = i - 1)
				g2b[i] = g2b[i + 1] ^ g[i];
		end
	endfunction

	dprfe_port u_port_a (
		.clk(ref_clk), .rst(rst), .ce(ce_a), .en(en_a), .we(we_a), .addr(addr_a),
		.din(din_a), .addr_latch(addr_latch), .pipe_en(pipe_a), .wmode(wmode_a),
		.cap_rd(cap_rd_a), .cap_wr(cap_wr_a), .rd_val(rd_a), .wr_val(wv_a),
		.go(go_a), .we_q(we_qa), .addr_q(aq_a), .din_q(dq_a), .dout(out_a)
	);
	dprfe_port u_port_b (
		.clk(ref_clk), .rst(rst), .ce(ce_b), .en(en_b), .we(we_b), .addr(addr_b),
		.din(din_b), .addr_latch(addr_latch), .pipe_en(pipe_b), .wmode(wmode_b),
		.cap_rd(cap_rd_b), .cap_wr(cap_wr_b), .rd_val(rd_b), .wr_val(wv_b),
		.go(go_b), .we_q(we_qb), .addr_q(aq_b), .din_q(dq_b), .dout(out_b)
	);

	assign dout_a = out_a[`DPRFE_WW-1:0];
	assign dout_b = out_b[`DPRFE_WW-1:0];
	assign casc_out = out_b[`DPRFE_WW-1:0];
	assign sbit_err = out_b[`DPRFE_OW-2];
	assign dbit_err = out_b[`DPRFE_OW-1];

	// Width clamps: the 72-bit code only when one side writes and one reads
	always @* begin
		if (split_read_write_mode)
			ca = half_mode ? `DPRFE_C36 : `DPRFE_C72;
		else if (half_mode)
			ca = (wcode_a > `DPRFE_C18) ? `DPRFE_C18 : wcode_a;
		else
			ca = (wcode_a > `DPRFE_C36) ? `DPRFE_C36 : wcode_a;
		if (split_read_write_mode)
			cb = (wcode_b > ca) ? ca : wcode_b;
		else if (half_mode)
			cb = (wcode_b > `DPRFE_C18) ? `DPRFE_C18 : wcode_b;
		else
			cb = (wcode_b > `DPRFE_C36) ? `DPRFE_C36 : wcode_b;
	end

	// FIFO fill in slots: a slot is one sixty-fourth of a word
	always @* begin
		cap = fifo_half ? `DPRFE_CAP_HALF : `DPRFE_CAP_FULL;
		step_w = 17'h00001 << ca;
		step_r = 17'h00001 << cb;
		r_seen = fifo_dual ? g2b(rg_s2) : rcnt_reg;
		w_seen = fifo_dual ? g2b(wg_s2) : wcnt_reg;
		wslot = wcnt_reg << ca;
		rslot = r_seen << cb;
		fill_w = wslot - rslot;
		full_now = ({1'b0, fill_w} + step_w) > cap;
		wslot = w_seen << ca;
		rslot = rcnt_reg << cb;
		fill_r = wslot - rslot;
		empty_now = {1'b0, fill_r} < step_r;
		wr_fire = fifo_mode & go_a & we_qa & ~full_now & ~sleep_reg;
		rd_fire = fifo_mode & go_b & ~empty_now & ~sleep_reg;
		wcnt_next = wcnt_reg + {{(`DPRFE_PW-1){1'b0}}, wr_fire};
		rcnt_next = rcnt_reg + {{(`DPRFE_PW-1){1'b0}}, rd_fire};
	end

	// Address, lane and access strobes for both ports
	always @* begin
		ea = fifo_mode ? wcnt_reg[`DPRFE_AW-1:0] : aq_a;
		eb = fifo_mode ? rcnt_reg[`DPRFE_AW-1:0] : aq_b;
		word_a = word_of(ea, ca, half_mode | fifo_half, half_sel_a & ~fifo_mode);
		word_b = word_of(eb, cb, half_mode | fifo_half, half_sel_b & ~fifo_mode);
		off_a = off_of(ea, ca);
		off_b = off_of(eb, cb);
		mask_a = lmask(ca) << off_a;
		mask_b = lmask(cb) << off_b;
		if (ecc_en && ca == `DPRFE_C72)
			wdat_a = {ecc_chk(dq_a[`DPRFE_DW-1:0]), dq_a[`DPRFE_DW-1:0]};
		else
			wdat_a = dq_a << off_a;
		wa_fire = fifo_mode ? wr_fire : (go_a & we_qa & ~sleep_reg);
		wb_fire = go_b & we_qb & ~sleep_reg & ~split_read_write_mode & ~fifo_mode;
		cap_wr_a = wa_fire & ~fifo_mode;
		cap_wr_b = wb_fire;
		cap_rd_a = go_a & ~we_qa & ~sleep_reg & ~split_read_write_mode & ~fifo_mode;
		cap_rd_b = fifo_mode ? rd_fire : (go_b & ~we_qb & ~sleep_reg);
		rd_a = {2'b00, (mem[word_a] >> off_a) & lmask(ca)};
		rword_b = mem[word_b];
		dec_b = ecc_dec(rword_b);
		if (casc_sel_b)
			rd_b = {2'b00, casc_in};
		else if (ecc_en && cb == `DPRFE_C72)
			rd_b = dec_b;
		else
			rd_b = {2'b00, (rword_b >> off_b) & lmask(cb)};
		wv_a = {2'b00, dq_a & lmask(ca)};
		wv_b = {2'b00, dq_b & lmask(cb)};
	end

	// One write process; port B lands last on a same-word collision
	always @(posedge ref_clk) begin
		if (wa_fire)
			mem[word_a] <= (mem[word_a] & ~mask_a) | (wdat_a & mask_a);
		if (wb_fire)
			mem[word_b] <= (mem[word_b] & ~mask_b) | ((dq_b << off_b) & mask_b);
	end

	// Gated array keeps contents but takes no access
	always @(posedge ref_clk) begin
		if (rst)
			sleep_reg <= 1'b0;
		else
			sleep_reg <= pwr_gate;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			wcnt_reg <= {`DPRFE_PW{1'b0}};
			rcnt_reg <= {`DPRFE_PW{1'b0}};
			wgray_reg <= {`DPRFE_PW{1'b0}};
			rgray_reg <= {`DPRFE_PW{1'b0}};
			wg_s1 <= {`DPRFE_PW{1'b0}};
			wg_s2 <= {`DPRFE_PW{1'b0}};
			rg_s1 <= {`DPRFE_PW{1'b0}};
			rg_s2 <= {`DPRFE_PW{1'b0}};
			fifo_full <= 1'b0;
			fifo_empty <= 1'b1;
			fifo_almost_full <= 1'b0;
			fifo_almost_empty <= 1'b1;
		end else begin
			wcnt_reg <= wcnt_next;
			rcnt_reg <= rcnt_next;
			// Item counters step by one, so Gray changes one bit at a time
			wgray_reg <= wcnt_next ^ (wcnt_next >> 1);
			rgray_reg <= rcnt_next ^ (rcnt_next >> 1);
			wg_s1 <= wgray_reg;
			wg_s2 <= wg_s1;
			rg_s1 <= rgray_reg;
			rg_s2 <= rg_s1;
			fifo_full <= fifo_mode & full_now;
			fifo_empty <= ~fifo_mode | empty_now;
			fifo_almost_full <= fifo_mode & (fill_w >= af_thresh);
			fifo_almost_empty <= ~fifo_mode | (fill_r <= ae_thresh);
		end
	end

	// Standalone codec for external wide memories
	always @(posedge ref_clk) begin
		if (rst) begin
			enc_out <= {`DPRFE_WW{1'b0}};
			dec_out <= {`DPRFE_DW{1'b0}};
			dec_sbit <= 1'b0;
			dec_dbit <= 1'b0;
		end else begin
			enc_out <= {ecc_chk(enc_in), enc_in};
			dec_out <= dec_b_ext[`DPRFE_DW-1:0];
			dec_sbit <= dec_b_ext[`DPRFE_OW-2];
			dec_dbit <= dec_b_ext[`DPRFE_OW-1];
		end
	end

	assign dec_b_ext = ecc_dec(dec_in);
endmodule
`default_nettype wire

// *** tb/dprfe_props.sv ***
// Port-level checker for the dual-port memory with FIFO and check bits
`timescale 1ns/1ps
`default_nettype none
`include "dprfe_consts.vh"
module dprfe_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce_a,
	input wire logic en_a,
	input wire logic we_a,
	input wire logic [2:0] wcode_a,
	input wire logic pipe_a,
	input wire logic [1:0] wmode_a,
	input wire logic [`DPRFE_WW-1:0] din_a,
	input wire logic ce_b,
	input wire logic en_b,
	input wire logic we_b,
	input wire logic [2:0] wcode_b,
	input wire logic half_mode,
	input wire logic split_read_write_mode,
	input wire logic pwr_gate,
	input wire logic fifo_mode,
	input wire logic fifo_dual,
	input wire logic fifo_half,
	input wire logic [`DPRFE_DW-1:0] enc_in,
	input wire logic [`DPRFE_WW-1:0] dout_a,
	input wire logic [`DPRFE_WW-1:0] dout_b,
	input wire logic [`DPRFE_WW-1:0] casc_out,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	input wire logic fifo_almost_full,
	input wire logic fifo_almost_empty,
	input wire logic [`DPRFE_WW-1:0] enc_out,
	input wire logic dec_dbit
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire wr_a = ce_a && en_a && we_a;
	wire rd_b = ce_b && en_b;
	// B writes excluded: a collision on one word lets B win
	wire plain_a = !pwr_gate && !fifo_mode && !split_read_write_mode && !half_mode
		&& !pipe_a && !(ce_b && en_b && we_b);
	a_reset_flags: assert property ($fell(rst) |-> fifo_empty && fifo_almost_empty
		&& !fifo_full && !fifo_almost_full && dout_a == 72'h0) else $error("bad reset state");
	a_codec_pass: assert property (!$past(rst) |-> enc_out[63:0] == $past(enc_in))
		else $error("encoder data field wrong");
	a_flag_excl: assert property (!(fifo_full && fifo_empty)) else $error("full and empty");
	a_empty_aempty: assert property (fifo_empty |-> fifo_almost_empty)
		else $error("empty without almost empty");
	a_empty_drop: assert property (fifo_mode && !fifo_dual && !pwr_gate && !$past(pwr_gate)
		&& wr_a && !fifo_full && wcode_a == wcode_b |-> ##[1:4] !fifo_empty)
		else $error("write left fifo empty");
	a_full_hold: assert property (fifo_mode && $past(fifo_mode) && fifo_full && $stable(fifo_half)
		&& $stable(fifo_dual) && !rd_b && !$past(rd_b) && !$past(rd_b, 2) && !$past(rd_b, 3)
		&& !$past(rd_b, 4) |=> fifo_full || !fifo_mode)
		else $error("full dropped without read");
	a_empty_hold: assert property (fifo_mode && $past(fifo_mode) && fifo_empty
		&& $stable(fifo_half) && $stable(fifo_dual) && !wr_a && !$past(wr_a) && !$past(wr_a, 2)
		&& !$past(wr_a, 3) && !$past(wr_a, 4) |=> fifo_empty)
		else $error("empty dropped without write");
	a_write_first: assert property ($past(wr_a && wmode_a == 2'h1 && wcode_a == 3'h5 && plain_a, 3)
		&& !$past(pwr_gate, 4) && !pipe_a && !$past(pipe_a) |-> dout_a[35:0] == $past(din_a[35:0], 3))
		else $error("write-first output wrong");
	a_no_change: assert property ($past(wr_a && wmode_a == 2'h2 && plain_a, 2) && !pipe_a
		&& !$past(pipe_a) |=> $stable(dout_a)) else $error("no-change output moved");
	a_dout_hold: assert property (!$past(rst) && !$past(ce_a && en_a, 2) && !pipe_a
		&& !$past(pipe_a) && !$past(pipe_a, 2) |-> $stable(dout_a)) else $error("output not held");
	a_casc_copy: assert property (casc_out == dout_b) else $error("cascade output differs");
	c_no_change: cover property (wr_a && wmode_a == 2'h2);
	c_full: cover property (fifo_full);
	c_double: cover property ($rose(dec_dbit));
endmodule
bind dprfe_ram dprfe_props u_dprfe_props (.*);
`default_nettype wire

// *** tb/dprfe_user.sv ***
// User logic model driving memory port B
`timescale 1ns/1ps
`default_nettype none
`include "dprfe_consts.vh"
module dprfe_user (
	input wire logic ref_clk,
	output logic ce_b,
	output logic en_b,
	output logic we_b,
	output logic [`DPRFE_AW-1:0] addr_b,
	output logic [`DPRFE_WW-1:0] din_b
);
	initial begin
		ce_b = 1'b0;
		en_b = 1'b0;
		we_b = 1'b0;
		addr_b = 15'h0000;
		din_b = 72'h0;
	end
	// Clock enable stays up so the output pipeline keeps advancing
	task op(input logic w, input logic [14:0] a, input logic [71:0] d);
		@(posedge ref_clk);
		ce_b <= 1'b1;
		en_b <= 1'b1;
		we_b <= w;
		addr_b <= a;
		din_b <= d;
		@(posedge ref_clk);
		en_b <= 1'b0;
		we_b <= 1'b0;
		// Released data shows inverse so stale values never match
		din_b <= ~d;
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the dual-port memory with FIFO and check bits
`timescale 1ns/1ps
`default_nettype none
`include "dprfe_consts.vh"
module testbench;
	localparam logic [63:0] CODE_DATA = 64'h0123456789ABCDEF;
	logic ref_clk = 1'b0, rst = 1'b1, ce_a = 1'b0, en_a = 1'b0, we_a = 1'b0, pipe_a = 1'b0;
	logic pwr_gate = 1'b0, fifo_mode = 1'b0, fifo_half = 1'b0, ecc_en = 1'b0, casc_sel_b = 1'b0;
	logic split_read_write_mode = 1'b0, fifo_dual = 1'b0;
	logic [`DPRFE_AW-1:0] addr_a = 15'h0000;
	logic [`DPRFE_WW-1:0] din_a = 72'h0, casc_in = 72'h0, dec_in = 72'h0, cw, ev;
	logic [2:0] wcode_a = 3'h5, wcode_b = 3'h5;
	logic [1:0] wmode_a = 2'h0;
	logic [`DPRFE_PW-1:0] af_thresh = 16'h0040, ae_thresh = 16'h0020;
	logic [`DPRFE_DW-1:0] enc_in = 64'h0;
	wire ce_b, en_b, we_b, sbit_err, dbit_err, fifo_full, fifo_empty, fifo_almost_full;
	wire fifo_almost_empty, dec_sbit, dec_dbit;
	wire [`DPRFE_AW-1:0] addr_b;
	wire [`DPRFE_WW-1:0] din_b, dout_a, dout_b, casc_out, enc_out;
	wire [`DPRFE_DW-1:0] dec_out;
	int fail_count = 0, n_compared = 0, i;
	dprfe_user u_dprfe_user (.*);
	dprfe_ram u_dprfe_ram (.half_sel_a(1'b0), .half_sel_b(1'b0), .pipe_b(pipe_a), .wmode_b(wmode_a),
		.addr_latch(1'b1), .half_mode(1'b0), .*);
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task chk(input logic [71:0] got, input logic [71:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
			fail_count = fail_count + 1;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task opa(input logic w, input logic [14:0] a, input logic [71:0] d);
		@(posedge ref_clk);
		en_a <= 1'b1;
		we_a <= w;
		addr_a <= a;
		din_a <= d;
		@(posedge ref_clk);
		en_a <= 1'b0;
		we_a <= 1'b0;
		din_a <= ~d;
	endtask
	task print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count = fail_count + 1;
		print_verdict;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		ce_a <= 1'b1;
		wt(1);
		chk({fifo_full, fifo_empty, fifo_almost_full, fifo_almost_empty, dout_a[67:0]}, {4'h5, 68'h0});
		$display("reset test done");
		// Write 36-bit item, read back on A, then as 18-bit items on B
		opa(1'b1, 15'h0002, 72'h9ABCDEF01);
		opa(1'b0, 15'h0002, 72'h0);
		wt(1);
		chk(dout_a, 72'h9ABCDEF01);
		wcode_b <= 3'h4;
		u_dprfe_user.op(1'b0, 15'h0004, 72'h0);
		wt(1);
		chk(dout_b, 72'h1EF01);
		u_dprfe_user.op(1'b0, 15'h0005, 72'h0);
		wt(4);
		chk(dout_b, 72'h26AF3);
		wcode_b <= 3'h5;
		$display("aspect test done");
		// Previous output differs from old contents, so all three modes tell apart
		opa(1'b1, 15'h0010, 72'h123456789);
		ev = 72'h123456789;
		for (i = 0; i < 3; i = i + 1) begin
			wmode_a <= i[1:0];
			opa(1'b0, 15'h0002, 72'h0);
			opa(1'b1, 15'h0010, 72'h5A5A5A5A0 + i);
			wt(1);
			chk(dout_a, i == 0 ? ev : i == 1 ? 72'h5A5A5A5A0 + i : 72'h9ABCDEF01);
			ev = 72'h5A5A5A5A0 + i;
		end
		wmode_a <= 2'h0;
		pipe_a <= 1'b1;
		opa(1'b0, 15'h0010, 72'h0);
		wt(1);
		chk(dout_a, 72'h9ABCDEF01);
		wt(1);
		chk(dout_a, ev);
		pipe_a <= 1'b0;
		pwr_gate <= 1'b1;
		wt(2);
		opa(1'b1, 15'h0010, 72'hDEAD);
		wt(2);
		pwr_gate <= 1'b0;
		wt(2);
		opa(1'b0, 15'h0010, 72'h0);
		wt(1);
		chk(dout_a, ev);
		$display("port mode test done");
		enc_in <= CODE_DATA;
		wt(2);
		chk({8'h0, enc_out[63:0]}, {8'h0, CODE_DATA});
		cw = enc_out;
		for (i = 0; i < 3; i = i + 1) begin
			dec_in <= cw ^ (i == 0 ? 72'h0 : i == 1 ? (72'h1 << 40) : (72'h3 << 9));
			wt(2);
			chk({6'h0, dec_dbit, dec_sbit, i == 2 ? 64'h0 : dec_out},
				{6'h0, i == 2 ? 2'h2 : {1'b0, i[0]}, i == 2 ? 64'h0 : CODE_DATA});
		end
		// Split mode: B write must not land, B reads checked word
		split_read_write_mode <= 1'b1;
		ecc_en <= 1'b1;
		wcode_a <= 3'h6;
		wcode_b <= 3'h6;
		opa(1'b1, 15'h0003, {8'h0, ~CODE_DATA});
		u_dprfe_user.op(1'b1, 15'h0003, 72'h0);
		u_dprfe_user.op(1'b0, 15'h0003, 72'h0);
		wt(1);
		chk({6'h0, sbit_err, dbit_err, dout_b[63:0]}, {8'h0, ~CODE_DATA});
		casc_sel_b <= 1'b1;
		casc_in <= 72'hC3C3C3C3C3C3C3C3C3;
		u_dprfe_user.op(1'b0, 15'h0000, 72'h0);
		wt(1);
		chk(casc_out, 72'hC3C3C3C3C3C3C3C3C3);
		casc_sel_b <= 1'b0;
		split_read_write_mode <= 1'b0;
		ecc_en <= 1'b0;
		wcode_a <= 3'h5;
		wcode_b <= 3'h5;
		$display("codec test done");
		// Half FIFO of 36-bit items holds 512; thresholds are 2 and 1 items
		fifo_mode <= 1'b1;
		fifo_half <= 1'b1;
		wt(3);
		for (i = 0; i < 512; i = i + 1) begin
			opa(1'b1, 15'h0000, {60'h0, i[11:0]});
			if (i == 0) begin
				wt(3);
				chk({fifo_full, fifo_empty, fifo_almost_full, fifo_almost_empty}, 4'h1);
			end
		end
		wt(3);
		chk({fifo_full, fifo_empty, fifo_almost_full, fifo_almost_empty}, 4'hA);
		opa(1'b1, 15'h0000, 72'hFFF);
		for (i = 0; i < 512; i = i + 1) begin
			u_dprfe_user.op(1'b0, 15'h0000, 72'h0);
			wt(1);
			chk(dout_b, {60'h0, i[11:0]});
		end
		wt(3);
		chk({fifo_full, fifo_empty, fifo_almost_full, fifo_almost_empty}, 4'h5);
		// Dual-rate flags from synchronised pointers lag three cycles
		fifo_dual <= 1'b1;
		wt(2);
		u_dprfe_user.op(1'b0, 15'h0000, 72'h0);
		opa(1'b1, 15'h0000, 72'h77);
		wt(3);
		u_dprfe_user.op(1'b0, 15'h0000, 72'h0);
		wt(1);
		chk(dout_b, 72'h77);
		$display("fifo test done");
		print_verdict;
	end
endmodule
`default_nettype wire
